// ==== logic/single_op_defs.svh ====
// Constants for the single-operand instruction execution block
`ifndef SINGLE_OP_DEFS_SVH
`define SINGLE_OP_DEFS_SVH

// ****************************************************************
// Opcodes
// ****************************************************************
`define OPC_DEC_R 8'h00
`define OPC_DEC_IR 8'h01
`define OPC_INC_R 8'h20
`define OPC_INC_IR 8'h21
`define OPC_COM_R 8'h60
`define OPC_COM_IR 8'h61
`define OPC_IDLE 8'h6F
`define OPC_IRQ_OFF 8'h8F
`define OPC_IRQ_ON 8'h9F
`define OPC_CP_RR 8'hA2
`define OPC_CP_RIR 8'hA3
`define OPC_CP_FULL 8'hA4
`define OPC_CP_FULL_IND 8'hA5
`define OPC_CP_LIT 8'hA6
`define OPC_CLR_R 8'hB0
`define OPC_CLR_IR 8'hB1
`define OPC_INC_WORK_LO 4'hE

// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define REG_FLAGS 8'hD5
`define REG_STATUS 8'hDE
`define REG_SYSMODE 8'hDF
`define SYSMODE_IEN_BIT 2
`define STAT_SLEEP_BIT 0
`define STAT_BUSY_BIT 1
`define FLAG_C 7
`define FLAG_Z 6
`define FLAG_S 5
`define FLAG_V 4
`define FLAG_D 3
`define FLAG_H 2

// ****************************************************************
// Reset values and cycle counts
// ****************************************************************
`define FLAGS_RST 8'h00
`define IEN_RST 1'b0
`define CYC_SHORT 3'h4
`define CYC_LONG 3'h6

`endif

// ==== logic/single_op_pkg.sv ====
// Types shared by the single-operand instruction execution block
package single_op_pkg;

  typedef enum logic [3:0] {
    ST_OPC = 4'b0000,
    ST_B1 = 4'b0001,
    ST_B2 = 4'b0010,
    ST_SPTR = 4'b0011,
    ST_SRC = 4'b0100,
    ST_DPTR = 4'b0101,
    ST_DST = 4'b0110,
    ST_PAD = 4'b0111,
    ST_SLEEP = 4'b1000
  } seq_state_t;

  typedef enum logic [2:0] {
    ALU_NONE = 3'b000,
    ALU_CLR = 3'b001,
    ALU_COM = 3'b010,
    ALU_CP = 3'b011,
    ALU_DEC = 3'b100,
    ALU_INC = 3'b101
  } alu_op_t;

  typedef enum logic [1:0] {
    SYS_NONE = 2'b00,
    SYS_IRQ_OFF = 2'b01,
    SYS_IRQ_ON = 2'b10,
    SYS_IDLE = 2'b11
  } sys_op_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } rf_req_t;

  typedef struct packed {
    seq_state_t st;
    alu_op_t op;
    sys_op_t sys;
    logic [2:0] len;
    logic [2:0] cyc;
    logic two_b;
    logic dst_ind;
    logic src_ind;
    logic pair_form;
    logic src_first;
    logic [7:0] dst_addr;
    logic [7:0] src_addr;
    logic [7:0] src_val;
    logic [7:0] flags;
    logic ien;
    logic [7:0] rdata;
  } core_t;

endpackage

// ==== logic/single_op_alu.sv ====
// Result and flag computation for the single-operand instructions
`timescale 1ns/100ps
`include "single_op_defs.svh"

module single_op_alu (
  input wire single_op_pkg::alu_op_t op_i,
  input wire logic [7:0] dst_i,
  input wire logic [7:0] src_i,
  input wire logic [7:0] flags_i,
  output logic [7:0] res_o,
  output logic [7:0] flags_o,
  output logic wr_o
);

  logic [8:0] diff;

  always_comb begin
    diff = {1'b0, dst_i} - {1'b0, src_i};
    res_o = dst_i;
    flags_o = flags_i;
    wr_o = 1'b1;
    case (op_i)
      single_op_pkg::ALU_CLR: begin
        res_o = 8'h00;
      end
      single_op_pkg::ALU_COM: begin
        res_o = ~dst_i;
        flags_o[`FLAG_V] = 1'b0;
      end
      single_op_pkg::ALU_DEC: begin
        res_o = dst_i - 8'h01;
        flags_o[`FLAG_V] = (dst_i == 8'h80);
      end
      single_op_pkg::ALU_INC: begin
        res_o = dst_i + 8'h01;
        flags_o[`FLAG_V] = (dst_i == 8'h7F);
      end
      single_op_pkg::ALU_CP: begin
        res_o = diff[7:0];
        wr_o = 1'b0;
        flags_o[`FLAG_C] = diff[8];
        flags_o[`FLAG_V] = (dst_i[7] != src_i[7]) && (diff[7] == src_i[7]);
      end
      default: begin
        wr_o = 1'b0;
      end
    endcase
    if (op_i != single_op_pkg::ALU_CLR && op_i != single_op_pkg::ALU_NONE)
    begin
      flags_o[`FLAG_Z] = (res_o == 8'h00);
      flags_o[`FLAG_S] = res_o[7];
    end
  end

endmodule

// ==== logic/single_op_core.sv ====
// Decode and execution of the single-operand instruction group
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "single_op_defs.svh"

module single_op_core (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire single_op_pkg::bus_req_t bus_i,
  output logic [7:0] bus_rdata_o,
  input wire logic [7:0] code_byte_i,
  output logic code_take_o,
  input wire logic [7:0] wreg_base_i,
  output single_op_pkg::rf_req_t rf_o,
  input wire logic [7:0] rf_rdata_i,
  input wire logic irq_pend_i,
  output logic irq_take_o,
  output logic cpu_clk_en_o,
  output logic [7:0] flags_o,
  output logic ien_o,
  output logic unknown_op_o
);

  // ****************************************************************
  // State and datapath
  // ****************************************************************
  single_op_pkg::core_t core_reg;
  single_op_pkg::core_t core_next;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic alu_wr;
  logic [7:0] sm_view;
  logic [7:0] stat_view;
  logic fin;

  single_op_alu u_alu (
    .op_i(core_reg.op),
    .dst_i(rf_rdata_i),
    .src_i(core_reg.src_val),
    .flags_i(core_reg.flags),
    .res_o(alu_res),
    .flags_o(alu_flags),
    .wr_o(alu_wr)
  );

  assign fin = (core_reg.cyc == core_reg.len - 3'h1);
  assign flags_o = core_reg.flags;
  assign ien_o = core_reg.ien;
  assign bus_rdata_o = core_reg.rdata;
  assign cpu_clk_en_o = (core_reg.st != single_op_pkg::ST_SLEEP);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    core_next = core_reg;
    core_next.cyc = core_reg.cyc + 3'h1;
    rf_o = '0;
    code_take_o = 1'b0;
    irq_take_o = 1'b0;
    unknown_op_o = 1'b0;
    sm_view = 8'h00;
    sm_view[`SYSMODE_IEN_BIT] = core_reg.ien;
    stat_view = 8'h00;
    stat_view[`STAT_SLEEP_BIT] = !cpu_clk_en_o;
    stat_view[`STAT_BUSY_BIT] = (core_reg.st != single_op_pkg::ST_OPC);
    if (bus_i.rd) begin
      case (bus_i.addr)
        `REG_FLAGS: core_next.rdata = core_reg.flags;
        `REG_SYSMODE: core_next.rdata = sm_view;
        `REG_STATUS: core_next.rdata = stat_view;
        default: core_next.rdata = 8'h00;
      endcase
    end
    if (bus_i.wr) begin
      case (bus_i.addr)
        `REG_FLAGS: core_next.flags = bus_i.wdata;
        `REG_SYSMODE: core_next.ien = bus_i.wdata[`SYSMODE_IEN_BIT];
        default: ;
      endcase
    end
    case (core_reg.st)
      single_op_pkg::ST_OPC: begin
        core_next.cyc = 3'h0;
        if (core_reg.ien && irq_pend_i) begin
          irq_take_o = 1'b1;
          core_next.ien = 1'b0;
        end else begin
          code_take_o = 1'b1;
          core_next.cyc = 3'h1;
          core_next.op = single_op_pkg::ALU_NONE;
          core_next.sys = single_op_pkg::SYS_NONE;
          core_next.len = `CYC_SHORT;
          core_next.two_b = 1'b0;
          core_next.dst_ind = 1'b0;
          core_next.src_ind = 1'b0;
          core_next.pair_form = 1'b0;
          core_next.src_first = 1'b0;
          core_next.st = single_op_pkg::ST_B1;
          if (code_byte_i[3:0] == `OPC_INC_WORK_LO) begin
            core_next.op = single_op_pkg::ALU_INC;
            core_next.dst_addr = {wreg_base_i[7:4], code_byte_i[7:4]};
            core_next.st = single_op_pkg::ST_DST;
          end else begin
            case (code_byte_i)
              `OPC_CLR_R, `OPC_CLR_IR: begin
                core_next.op = single_op_pkg::ALU_CLR;
                core_next.dst_ind = code_byte_i[0];
              end
              `OPC_COM_R, `OPC_COM_IR: begin
                core_next.op = single_op_pkg::ALU_COM;
                core_next.dst_ind = code_byte_i[0];
              end
              `OPC_DEC_R, `OPC_DEC_IR: begin
                core_next.op = single_op_pkg::ALU_DEC;
                core_next.dst_ind = code_byte_i[0];
              end
              `OPC_INC_R, `OPC_INC_IR: begin
                core_next.op = single_op_pkg::ALU_INC;
                core_next.dst_ind = code_byte_i[0];
              end
              `OPC_CP_RR, `OPC_CP_RIR: begin
                core_next.op = single_op_pkg::ALU_CP;
                core_next.pair_form = 1'b1;
                core_next.src_ind = code_byte_i[0];
                core_next.len = code_byte_i[0] ? `CYC_LONG : `CYC_SHORT;
              end
              `OPC_CP_FULL, `OPC_CP_FULL_IND: begin
                core_next.op = single_op_pkg::ALU_CP;
                core_next.two_b = 1'b1;
                core_next.src_first = 1'b1;
                core_next.src_ind = code_byte_i[0];
                core_next.len = `CYC_LONG;
              end
              `OPC_CP_LIT: begin
                core_next.op = single_op_pkg::ALU_CP;
                core_next.two_b = 1'b1;
                core_next.len = `CYC_LONG;
              end
              `OPC_IRQ_OFF: begin
                core_next.sys = single_op_pkg::SYS_IRQ_OFF;
                core_next.ien = 1'b0;
                core_next.st = single_op_pkg::ST_PAD;
              end
              `OPC_IRQ_ON: begin
                core_next.sys = single_op_pkg::SYS_IRQ_ON;
                core_next.ien = 1'b1;
                core_next.st = single_op_pkg::ST_PAD;
              end
              `OPC_IDLE: begin
                core_next.sys = single_op_pkg::SYS_IDLE;
                core_next.st = single_op_pkg::ST_PAD;
              end
              default: begin
                // Foreign opcode: one byte consumed, 4 cycles in all (fetch plus 3 idle)
                unknown_op_o = 1'b1;
                core_next.st = single_op_pkg::ST_PAD;
              end
            endcase
          end
        end
      end
      single_op_pkg::ST_B1: begin
        code_take_o = 1'b1;
        if (core_reg.pair_form) begin
          core_next.dst_addr = {wreg_base_i[7:4], code_byte_i[7:4]};
          core_next.src_addr = {wreg_base_i[7:4], code_byte_i[3:0]};
          core_next.st = core_reg.src_ind ? single_op_pkg::ST_SPTR
                                          : single_op_pkg::ST_SRC;
        end else if (core_reg.src_first) begin
          core_next.src_addr = code_byte_i;
          core_next.st = single_op_pkg::ST_B2;
        end else begin
          core_next.dst_addr = code_byte_i;
          if (core_reg.two_b) begin
            core_next.st = single_op_pkg::ST_B2;
          end else if (core_reg.dst_ind) begin
            core_next.st = single_op_pkg::ST_DPTR;
          end else begin
            core_next.st = single_op_pkg::ST_DST;
          end
        end
      end
      single_op_pkg::ST_B2: begin
        code_take_o = 1'b1;
        if (core_reg.src_first) begin
          core_next.dst_addr = code_byte_i;
          core_next.st = core_reg.src_ind ? single_op_pkg::ST_SPTR
                                          : single_op_pkg::ST_SRC;
        end else begin
          core_next.src_val = code_byte_i;
          core_next.st = single_op_pkg::ST_DST;
        end
      end
      single_op_pkg::ST_SPTR: begin
        rf_o.rd = 1'b1;
        rf_o.addr = core_reg.src_addr;
        core_next.src_addr = rf_rdata_i;
        core_next.st = single_op_pkg::ST_SRC;
      end
      single_op_pkg::ST_SRC: begin
        rf_o.rd = 1'b1;
        rf_o.addr = core_reg.src_addr;
        core_next.src_val = rf_rdata_i;
        core_next.st = single_op_pkg::ST_DST;
      end
      single_op_pkg::ST_DPTR: begin
        rf_o.rd = 1'b1;
        rf_o.addr = core_reg.dst_addr;
        core_next.dst_addr = rf_rdata_i;
        core_next.st = single_op_pkg::ST_DST;
      end
      single_op_pkg::ST_DST: begin
        rf_o.addr = core_reg.dst_addr;
        rf_o.rd = (core_reg.op != single_op_pkg::ALU_CLR);
        rf_o.wr = alu_wr;
        rf_o.wdata = alu_res;
        core_next.flags = alu_flags;
        if (fin) begin
          core_next.cyc = 3'h0;
          core_next.st = single_op_pkg::ST_OPC;
        end else begin
          core_next.st = single_op_pkg::ST_PAD;
        end
      end
      single_op_pkg::ST_PAD: begin
        if (fin) begin
          core_next.cyc = 3'h0;
          core_next.st = (core_reg.sys == single_op_pkg::SYS_IDLE)
                         ? single_op_pkg::ST_SLEEP : single_op_pkg::ST_OPC;
        end
      end
      single_op_pkg::ST_SLEEP: begin
        core_next.cyc = 3'h0;
        if (irq_pend_i) begin
          core_next.st = single_op_pkg::ST_OPC;
        end
      end
      default: begin
        core_next.st = single_op_pkg::ST_OPC;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_reg <= '0;
      core_reg.st <= single_op_pkg::ST_OPC;
      core_reg.len <= `CYC_SHORT;
      core_reg.flags <= `FLAGS_RST;
      core_reg.ien <= `IEN_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_clr_timing;
    @(posedge clk_i) disable iff (!rstn_i)
    (code_take_o && core_reg.st == single_op_pkg::ST_OPC &&
     code_byte_i == `OPC_CLR_R) |=>
    (core_reg.st != single_op_pkg::ST_OPC)[*3]
    ##1 (core_reg.st == single_op_pkg::ST_OPC);
  endproperty
  a_clr_timing: assert property (p_clr_timing)
    else $error("clear did not take 4 cycles");

  property p_clr_write;
    @(posedge clk_i) disable iff (!rstn_i)
    (core_reg.st == single_op_pkg::ST_DST &&
     core_reg.op == single_op_pkg::ALU_CLR) |->
    (rf_o.wr && rf_o.wdata == 8'h00) ##1 $stable(flags_o);
  endproperty
  a_clr_write: assert property (p_clr_write)
    else $error("clear wrote nonzero or changed flags");

  property p_ind_target;
    @(posedge clk_i) disable iff (!rstn_i)
    (core_reg.st == single_op_pkg::ST_DPTR) |=>
    (core_reg.st == single_op_pkg::ST_DST && rf_o.addr == $past(rf_rdata_i));
  endproperty
  a_ind_target: assert property (p_ind_target)
    else $error("indirect write missed the pointed register");

  property p_com_flags;
    @(posedge clk_i) disable iff (!rstn_i)
    (core_reg.st == single_op_pkg::ST_DST &&
     core_reg.op == single_op_pkg::ALU_COM) |->
    (rf_o.wdata == ~rf_rdata_i) ##1
    (!flags_o[`FLAG_V] && flags_o[`FLAG_S] == $past(rf_o.wdata[7]));
  endproperty
  a_com_flags: assert property (p_com_flags)
    else $error("complement result or flags wrong");

  property p_cp_long;
    @(posedge clk_i) disable iff (!rstn_i)
    (code_take_o && core_reg.st == single_op_pkg::ST_OPC &&
     code_byte_i == `OPC_CP_FULL_IND) |->
    ##6 (core_reg.st == single_op_pkg::ST_OPC);
  endproperty
  a_cp_long: assert property (p_cp_long)
    else $error("compare did not take 6 cycles");

  property p_cp_carry;
    @(posedge clk_i) disable iff (!rstn_i)
    (core_reg.st == single_op_pkg::ST_DST &&
     core_reg.op == single_op_pkg::ALU_CP) |->
    !rf_o.wr ##1
    (flags_o[`FLAG_C] == ($past(core_reg.src_val) > $past(rf_rdata_i)));
  endproperty
  a_cp_carry: assert property (p_cp_carry)
    else $error("compare carry wrong or operand written");

  property p_dec_ovf;
    @(posedge clk_i) disable iff (!rstn_i)
    (core_reg.st == single_op_pkg::ST_DST &&
     core_reg.op == single_op_pkg::ALU_DEC) |=>
    (flags_o[`FLAG_V] == ($past(rf_rdata_i) == 8'h80));
  endproperty
  a_dec_ovf: assert property (p_dec_ovf)
    else $error("decrement overflow wrong");

  property p_inc_ovf;
    @(posedge clk_i) disable iff (!rstn_i)
    (core_reg.st == single_op_pkg::ST_DST &&
     core_reg.op == single_op_pkg::ALU_INC) |=>
    (flags_o[`FLAG_V] == ($past(rf_rdata_i) == 8'h7F));
  endproperty
  a_inc_ovf: assert property (p_inc_ovf)
    else $error("increment overflow wrong");

  property p_irq_blocked;
    @(posedge clk_i) disable iff (!rstn_i)
    (core_reg.st == single_op_pkg::ST_OPC && !ien_o) |->
    (code_take_o && !irq_take_o);
  endproperty
  a_irq_blocked: assert property (p_irq_blocked)
    else $error("interrupt taken while disabled");

  property p_irq_on;
    @(posedge clk_i) disable iff (!rstn_i)
    (code_take_o && core_reg.st == single_op_pkg::ST_OPC &&
     code_byte_i == `OPC_IRQ_ON) |=> ien_o [*3] ##1
    (!irq_pend_i || irq_take_o);
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("pending request not serviced after enable");

  property p_idle_wake;
    @(posedge clk_i) disable iff (!rstn_i)
    (core_reg.st == single_op_pkg::ST_SLEEP) |=>
    (cpu_clk_en_o == $past(irq_pend_i));
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle exit wrong");

endmodule

// ==== tb/rf_prog_model.sv ====
// Register file and program byte stream facing the instruction block
`timescale 1ns/100ps
module rf_prog_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire single_op_pkg::rf_req_t rf_i,
  output logic [7:0] rf_rdata_o,
  input wire logic take_i,
  output logic [7:0] code_byte_o
);
  logic [7:0] rf_mem [256];
  logic [7:0] code_mem [256];
  logic [7:0] pc_reg;
  logic [7:0] last_reg;

  // Unused code space holds an opcode outside the group
  initial begin
    for (int i = 0; i < 256; i++) begin
      rf_mem[i] = 8'h00;
      code_mem[i] = 8'hFF;
    end
    last_reg = 8'h00;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_reg <= 8'h00;
    end else if (take_i) begin
      pc_reg <= pc_reg + 8'h01;
    end
  end

  always @(posedge clk_i) begin
    if (rf_i.wr) begin
      rf_mem[rf_i.addr] <= rf_i.wdata;
    end
    if (rf_i.rd) begin
      last_reg <= rf_mem[rf_i.addr];
    end
  end

  // Read data is only meaningful while a read is requested
  assign rf_rdata_o = rf_i.rd ? rf_mem[rf_i.addr] : ~last_reg;
  assign code_byte_o = code_mem[pc_reg];
endmodule

// ==== tb/cpu_single_operand_ops_tb.sv ====
// Self-checking bench for the single-operand instruction block
`timescale 1ns/100ps
module cpu_single_operand_ops_tb;
  logic clk_i;
  logic rstn_i;
  logic irq_pend_i;
  single_op_pkg::bus_req_t bus;
  single_op_pkg::rf_req_t rf;
  logic [7:0] wreg_base;
  logic [7:0] rdata;
  logic [7:0] code_byte;
  logic [7:0] rf_rdata;
  logic [7:0] flags;
  logic take;
  logic irq_take;
  logic clk_en;
  logic ien;
  logic unk;
  int err_count;
  int n_tests;
  int cyc;
  int irq_seen;
  // Opcode, destination, source, preset flags
  localparam logic [31:0] ROWS [14] = '{
    32'hB04F_00F0, 32'hB15E_000C, 32'h6007_00FC, 32'h61FF_0010,
    32'h0080_0000, 32'h0101_0080, 32'h207F_0000, 32'h21FF_000C,
    32'h1E0F_00FC, 32'hA202_030C, 32'hA305_0500, 32'hA480_0100,
    32'hA57F_FF00, 32'hA610_20F0};

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (irq_take === 1'b1) irq_seen <= irq_seen + 1;
  end

  single_op_core i_single_op_core (
    .clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus), .bus_rdata_o(rdata),
    .code_byte_i(code_byte), .code_take_o(take), .wreg_base_i(wreg_base),
    .rf_o(rf), .rf_rdata_i(rf_rdata), .irq_pend_i(irq_pend_i),
    .irq_take_o(irq_take), .cpu_clk_en_o(clk_en), .flags_o(flags),
    .ien_o(ien), .unknown_op_o(unk));

  rf_prog_model i_rf_prog_model (
    .clk_i(clk_i), .rstn_i(rstn_i), .rf_i(rf), .rf_rdata_o(rf_rdata),
    .take_i(take), .code_byte_o(code_byte));

  function automatic logic [15:0] ref_op(input logic [7:0] op, d, s, f);
    logic [7:0] x;
    logic v;
    logic c;
    c = f[7];
    v = 1'b0;
    case (op)
      8'hB0, 8'hB1: return {8'h00, f};
      8'h60, 8'h61: x = ~d;
      8'h00, 8'h01: begin
        x = d - 8'h01;
        v = (d == 8'h80);
      end
      8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6: begin
        x = d - s;
        c = (s > d);
        v = (d[7] != s[7]) && (x[7] == s[7]);
      end
      default: begin
        x = d + 8'h01;
        v = (d == 8'h7F);
      end
    endcase
    return {(op[7:4] == 4'hA) ? d : x, c, x == 8'h00, x[7], v, f[3:0]};
  endfunction

  task automatic close_out;
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, e);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    @(negedge clk_i);
    chk(what, e, rdata);
  endtask

  task automatic wait_take(input logic [7:0] a);
    for (int k = 0; k < 64; k++) begin
      @(negedge clk_i);
      if (take === 1'b1 && i_rf_prog_model.pc_reg === a) return;
    end
    chk("fetch", a, i_rf_prog_model.pc_reg);
  endtask

  task automatic place(input logic [23:0] code, input int len,
                       output logic [7:0] p);
    p = i_rf_prog_model.pc_reg + 8'h04;
    for (int i = 0; i < len; i++)
      i_rf_prog_model.code_mem[p + 8'(i)] = code[23 - 8 * i -: 8];
  endtask

  task automatic run(input logic [23:0] code, input int len, ncyc);
    logic [7:0] p;
    int t0;
    place(code, len, p);
    wait_take(p);
    chk("known_op", 8'h00, {7'h00, unk});
    t0 = cyc;
    wait_take(p + 8'(len));
    chk("foreign_op", 8'h01, {7'h00, unk});
    if (ncyc > 0) chk("cycles", 8'(ncyc), 8'(cyc - t0));
    for (int i = 0; i < len; i++)
      i_rf_prog_model.code_mem[p + 8'(i)] = 8'hFF;
  endtask

  initial begin
    repeat (6000) @(posedge clk_i);
    err_count++;
    close_out;
  end

  initial begin
    logic [7:0] op, d, s, f, p;
    logic [15:0] e;
    logic [23:0] code;
    int len;
    rstn_i = 1'b0;
    irq_pend_i = 1'b0;
    wreg_base = 8'h20;
    bus = '0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    chk("flags_rst", 8'h00, flags);
    wr(8'h40, 8'h5A);
    rd_chk("unmapped", 8'h40, 8'h00);
    // Every ALU opcode form with boundary operands
    foreach (ROWS[i]) begin
      {op, d, s, f} = ROWS[i];
      i_rf_prog_model.rf_mem[8'h21] = d;
      i_rf_prog_model.rf_mem[8'h22] = s;
      i_rf_prog_model.rf_mem[8'h23] = 8'h22;
      i_rf_prog_model.rf_mem[8'h30] = 8'h21;
      wr(8'hD5, f);
      case (op)
        8'hA2: code = {op, 8'h12, 8'h00};
        8'hA3: code = {op, 8'h13, 8'h00};
        8'hA4: code = {op, 8'h22, 8'h21};
        8'hA5: code = {op, 8'h23, 8'h21};
        8'hA6: code = {op, 8'h21, s};
        default: code = {op, op[0] ? 8'h30 : 8'h21, 8'h00};
      endcase
      len = (op == 8'h1E) ? 1 : (op >= 8'hA4 && op <= 8'hA6) ? 3 : 2;
      e = ref_op(op, d, s, f);
      run(code, len, (op >= 8'hA3 && op <= 8'hA6) ? 6 : 4);
      chk("result", e[15:8], i_rf_prog_model.rf_mem[8'h21]);
      chk("flags", e[7:0], flags);
      chk("source", s, i_rf_prog_model.rf_mem[8'h22]);
      chk("pointer", 8'h21, i_rf_prog_model.rf_mem[8'h30]);
      rd_chk("flags_reg", 8'hD5, e[7:0]);
    end
    // Global interrupt enable and disable
    wr(8'hD5, 8'hA8);
    run({8'h9F, 16'h0000}, 1, 4);
    chk("ien_on", 8'h01, {7'h00, ien});
    rd_chk("sysmode_on", 8'hDF, 8'h04);
    run({8'h8F, 16'h0000}, 1, 4);
    chk("ien_off", 8'h00, {7'h00, ien});
    rd_chk("sysmode_off", 8'hDF, 8'h00);
    chk("flags_kept", 8'hA8, flags);
    @(posedge clk_i);
    irq_pend_i <= 1'b1;
    repeat (20) @(negedge clk_i);
    chk("no_vector", 8'h00, 8'(irq_seen));
    run({8'h9F, 16'h0000}, 1, 0);
    repeat (4) @(negedge clk_i);
    chk("vectored", 8'h01, 8'(irq_seen));
    @(posedge clk_i);
    irq_pend_i <= 1'b0;
    // Idle, left by a request
    place({8'h6F, 16'h0000}, 1, p);
    wait_take(p);
    repeat (6) @(negedge clk_i);
    chk("idle", 8'h00, {7'h00, clk_en});
    chk("idle_pc", p + 8'h01, i_rf_prog_model.pc_reg);
    rd_chk("status_idle", 8'hDE, 8'h03);
    @(posedge clk_i);
    irq_pend_i <= 1'b1;
    @(posedge clk_i);
    irq_pend_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk("wake", 8'h01, {7'h00, clk_en});
    i_rf_prog_model.code_mem[p] = 8'hFF;
    // Idle, left by reset
    wr(8'hD5, 8'hF0);
    place({8'h6F, 16'h0000}, 1, p);
    wait_take(p);
    repeat (6) @(negedge clk_i);
    chk("idle2", 8'h00, {7'h00, clk_en});
    @(posedge clk_i);
    rstn_i <= 1'b0;
    @(negedge clk_i);
    chk("wake_rst", 8'h01, {7'h00, clk_en});
    i_rf_prog_model.code_mem[p] = 8'hFF;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    chk("flags_rst2", 8'h00, flags);
    run({8'h20, 8'h21, 8'h00}, 2, 4);
    close_out;
  end
endmodule
